// >>> logic/byte_port_pkg.sv
// Constants and types shared by the byte-wide register port
`default_nettype none
package byte_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 64;
  localparam logic [5:0] USER_FIRST = 6'h0e;
  localparam logic [5:0] USER_LAST = 6'h3f;
  localparam int POWER_RECOVERY_INTERVAL_NS = 2000;
  localparam int POWER_RECOVERY_CYC =
    (POWER_RECOVERY_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUTPUT_DISABLE_DELAY_NS = 40;
  localparam int OUTPUT_DISABLE_CYC =
    (OUTPUT_DISABLE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
    OUTPUT_DISABLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    st_down = 2'b00,
    st_recover = 2'b01,
    st_live = 2'b11
  } power_state_type;

  typedef enum logic {
    st_idle = 1'b0,
    st_write = 1'b1
  } access_state_type;

  function automatic logic is_user_byte(input logic [5:0] addr);
    is_user_byte = (addr >= USER_FIRST) && (addr <= USER_LAST);
  endfunction : is_user_byte
endpackage : byte_port_pkg
`default_nettype wire

// >>> logic/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and synchronised copy
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage_one;
  logic [W-1:0] stage_two;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_one <= INIT;
      stage_two <= INIT;
    end else begin
      stage_one <= i_async;
      stage_two <= stage_one;
    end
  end

  assign o_sync = stage_two;
endmodule : pin_sync
`default_nettype wire

// >>> logic/reg_store.sv
// Storage for the 64 byte-wide registers, one write and one read port
`default_nettype none
module reg_store
  import byte_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_wr,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data,
  // Read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data
);
  // Battery-backed contents: no reset, values survive a logic reset
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_addr];
endmodule : reg_store
`default_nettype wire

// >>> logic/async_bytewide_register_port.sv
// SRAM-style byte-wide register port with power-fail protection
`default_nettype none
module async_bytewide_register_port
  import byte_port_pkg::*;
#(
  parameter int RECOVERY_CYC = POWER_RECOVERY_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus strobes, active low pins
  input wire logic i_chip_sel_n,
  input wire logic i_out_drive_n,
  input wire logic i_write_n,
  // Address and data bus
  input wire logic [ADDR_W-1:0] i_register_select_lines,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  // Supply monitor pin: high while supply is above the trip threshold
  input wire logic i_supply_ok,
  // Timekeeping core side
  input wire logic i_core_wr,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic [DATA_W-1:0] i_core_data,
  input wire logic i_irq_first_req,
  input wire logic i_irq_second_req,
  input wire logic i_second_active_high,
  // Open-drain interrupt pins
  output logic o_interrupt_out_first,
  output logic o_interrupt_out_first_oe,
  output logic o_interrupt_out_second,
  output logic o_interrupt_out_second_oe,
  // Status
  output logic o_bus_live
);
  localparam int SW = 3 + ADDR_W + DATA_W + 1;
  localparam int ODW_BOUND = OUTPUT_DISABLE_CYC;
  localparam logic [SW-1:0] SYNC_INIT = {3'b111, {(SW-3){1'b0}}};

  // Synchronised pins
  logic [SW-1:0] pins_sync;
  logic ce_n_s;
  logic oe_n_s;
  logic we_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic supply_s;

  pin_sync #(
    .W(SW),
    .INIT(SYNC_INIT)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_chip_sel_n, i_out_drive_n, i_write_n,
              i_register_select_lines, i_data, i_supply_ok}),
    .o_sync(pins_sync)
  );

  assign {ce_n_s, oe_n_s, we_n_s, addr_s, data_s, supply_s} = pins_sync;

  // Power supervisor
  power_state_type power_state;
  power_state_type next_power_state;
  logic [15:0] rec_count;
  logic [15:0] next_rec_count;
  logic live;

  always_comb begin
    next_power_state = power_state;
    next_rec_count = rec_count;
    unique case (power_state)
      st_down: begin
        next_rec_count = '0;
        if (supply_s) begin
          next_power_state = st_recover;
        end
      end
      st_recover: begin
        if (!supply_s) begin
          next_power_state = st_down;
          next_rec_count = '0;
        end else if (rec_count == 16'(RECOVERY_CYC - 1)) begin
          next_power_state = st_live;
          next_rec_count = '0;
        end else begin
          next_rec_count = rec_count + 16'h0001;
        end
      end
      st_live: begin
        if (!supply_s) begin
          next_power_state = st_down;
        end
      end
      default: begin
        next_power_state = st_down;
        next_rec_count = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      power_state <= st_down;
      rec_count <= '0;
    end else begin
      power_state <= next_power_state;
      rec_count <= next_rec_count;
    end
  end

  assign live = (power_state == st_live);

  // Write cycle tracking
  access_state_type access_state;
  access_state_type next_access_state;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] next_wr_data;
  logic wr_cond;
  logic bus_wr;

  // Both strobes low and supervisor in st_live; inputs are ignored otherwise
  assign wr_cond = live && !ce_n_s && !we_n_s;

  always_comb begin
    next_access_state = access_state;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    bus_wr = 1'b0;
    unique case (access_state)
      st_idle: begin
        if (wr_cond) begin
          next_access_state = st_write;
          next_wr_addr = addr_s;
          next_wr_data = data_s;
        end
      end
      st_write: begin
        if (!live) begin
          next_access_state = st_idle;
        end else if (ce_n_s || we_n_s) begin
          // First rising strobe ends the cycle; last sampled data is kept
          next_access_state = st_idle;
          bus_wr = 1'b1;
        end else begin
          next_wr_addr = addr_s;
          next_wr_data = data_s;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      access_state <= st_idle;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      access_state <= next_access_state;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // Register storage; core may only touch the timekeeping locations
  logic core_ok;
  logic mem_wr;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_data;
  logic [DATA_W-1:0] rd_data;

  assign core_ok = i_core_wr && !is_user_byte(i_core_addr);
  assign mem_wr = bus_wr || core_ok;
  assign mem_addr = bus_wr ? wr_addr : i_core_addr;
  assign mem_data = bus_wr ? wr_data : i_core_data;

  reg_store #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_store (
    .i_clk(i_clk),
    .i_wr(mem_wr),
    .i_wr_addr(mem_addr),
    .i_wr_data(mem_data),
    .i_rd_addr(addr_s),
    .o_rd_data(rd_data)
  );

  // Read drive and pin outputs
  logic read_cond;
  logic next_data_oe;
  logic [DATA_W-1:0] next_data;
  logic next_second_oe;
  logic second_active;

  assign read_cond = live && !ce_n_s && !oe_n_s && we_n_s;

  always_comb begin
    next_data_oe = read_cond;
    next_data = read_cond ? rd_data : o_data;
    // Core side keeps running whatever the supply does
    second_active = i_irq_second_req;
    if (i_second_active_high) begin
      // Released to the pullup only while main supply is present
      next_second_oe = !(second_active && supply_s);
    end else begin
      next_second_oe = second_active;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= '0;
      o_data_oe <= 1'b0;
      o_interrupt_out_first <= 1'b0;
      o_interrupt_out_first_oe <= 1'b0;
      o_interrupt_out_second <= 1'b0;
      o_interrupt_out_second_oe <= 1'b0;
      o_bus_live <= 1'b0;
    end else begin
      o_data <= next_data;
      o_data_oe <= next_data_oe;
      o_interrupt_out_first <= 1'b0;
      o_interrupt_out_first_oe <= i_irq_first_req;
      o_interrupt_out_second <= 1'b0;
      o_interrupt_out_second_oe <= next_second_oe;
      o_bus_live <= next_power_state == st_live;
    end
  end

  // Checks
  logic [15:0] good_run;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      good_run <= '0;
    end else if (!supply_s) begin
      good_run <= '0;
    end else if (good_run != 16'hffff) begin
      good_run <= good_run + 16'h0001;
    end
  end

  chk_read_drive: assert property (
    @(posedge i_clk) disable iff (i_rst)
    read_cond |=> o_data_oe && o_data == $past(rd_data))
    else $error("read did not drive selected register");

  chk_write_start: assert property (
    @(posedge i_clk) disable iff (i_rst)
    access_state == st_idle && live && !ce_n_s && !we_n_s
    |=> access_state == st_write && wr_addr == $past(addr_s))
    else $error("write cycle did not start");

  chk_write_end: assert property (
    @(posedge i_clk) disable iff (i_rst)
    access_state == st_write && live && (ce_n_s || we_n_s)
    |-> mem_wr && mem_addr == wr_addr && mem_data == wr_data
    ##1 access_state == st_idle)
    else $error("write end did not store data");

  chk_write_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    access_state == st_write |-> $past(wr_cond))
    else $error("write mode without both strobes low");

  chk_out_disable: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $fell(we_n_s) && o_data_oe |-> ##[1:ODW_BOUND] !o_data_oe)
    else $error("outputs not disabled after write strobe fell");

  chk_write_protect: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !live |-> !bus_wr ##1 !o_data_oe)
    else $error("bus active while supply low");

  chk_bus_recover: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(live) |-> good_run > 16'(RECOVERY_CYC))
    else $error("bus resumed before recovery interval");

  chk_open_drain: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !o_interrupt_out_first && !o_interrupt_out_second)
    else $error("interrupt pin driven high");

  chk_second_high: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $past(i_second_active_high) && $past(i_irq_second_req)
    && !$past(supply_s) |-> o_interrupt_out_second_oe)
    else $error("second interrupt released without supply");

  chk_irq_run: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_irq_first_req |=> o_interrupt_out_first_oe)
    else $error("first interrupt not asserted");

  chk_user_bytes: assert property (
    @(posedge i_clk) disable iff (i_rst)
    mem_wr && !bus_wr |-> mem_addr < USER_FIRST)
    else $error("core wrote a user byte");

  cov_read: cover property (@(posedge i_clk) disable iff (i_rst)
    read_cond ##1 o_data_oe);
  cov_write: cover property (@(posedge i_clk) disable iff (i_rst)
    bus_wr);
  cov_power_cycle: cover property (@(posedge i_clk) disable iff (i_rst)
    $fell(live) ##[1:1000] $rose(live));
endmodule : async_bytewide_register_port
`default_nettype wire

// >>> testbench/host_bus_model.sv
// Host model driving the byte port strobes and its half of the data bus
`default_nettype none
module host_bus_model
  import byte_port_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Device read side
  input wire logic i_dev_oe,
  input wire logic [DATA_W-1:0] i_dev_data,
  // Host strobes and bus
  output var logic o_ce_n,
  output var logic o_oe_n,
  output var logic o_we_n,
  output var logic [ADDR_W-1:0] o_addr,
  output var logic [DATA_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_ce_n = 1'h1;
    o_oe_n = 1'h1;
    o_we_n = 1'h1;
    o_addr = 6'h00;
    o_data = 8'h5a;
  end

  // One bus phase of n cycles; a released bus shows its inverted last value
  task automatic step(input logic ce, oe, we, input logic [5:0] a,
      input logic [7:0] d, input logic drive, input int n);
    @(posedge i_clk);
    o_ce_n <= ce;
    o_oe_n <= oe;
    o_we_n <= we;
    o_addr <= a;
    o_data <= drive ? d : ~o_data;
    repeat (n - 1) @(posedge i_clk);
  endtask : step

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    step(1'h0, 1'h1, 1'h0, a, d, 1'h1, 4);
    step(1'h1, 1'h1, 1'h1, a, d, 1'h1, 3);
    step(1'h1, 1'h1, 1'h1, a, d, 1'h0, 3);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] q,
      output logic seen);
    int k;
    seen = 1'h0;
    q = 8'h00;
    step(1'h0, 1'h0, 1'h1, a, 8'h00, 1'h0, 1);
    for (k = 0; k < 8 && !seen; k++) begin
      @(posedge i_clk);
      if (i_dev_oe === 1'h1) begin
        seen = 1'h1;
        q = i_dev_data;
      end
    end
    step(1'h1, 1'h1, 1'h1, a, 8'h00, 1'h0, 4);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// >>> testbench/async_bytewide_register_port_tb.sv
// Self-checking bench for the byte-wide register port
`default_nettype none
module async_bytewide_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import byte_port_pkg::*;
  localparam int RC = 8;
  localparam int LIMIT = 20000;
  logic i_clk, i_rst, sup, cwr, irq1, irq2, act_hi;
  logic [5:0] caddr;
  logic [7:0] cdata;
  logic ce_n, oe_n, we_n, doe, int1, int1_oe, int2, int2_oe, live;
  logic [5:0] addr;
  logic [7:0] hdata, odata, bus;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  assign bus = doe ? odata : hdata;

  async_bytewide_register_port #(.RECOVERY_CYC(RC)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_chip_sel_n(ce_n),
    .i_out_drive_n(oe_n), .i_write_n(we_n),
    .i_register_select_lines(addr), .i_data(bus), .o_data(odata),
    .o_data_oe(doe), .i_supply_ok(sup), .i_core_wr(cwr),
    .i_core_addr(caddr), .i_core_data(cdata), .i_irq_first_req(irq1),
    .i_irq_second_req(irq2), .i_second_active_high(act_hi),
    .o_interrupt_out_first(int1), .o_interrupt_out_first_oe(int1_oe),
    .o_interrupt_out_second(int2), .o_interrupt_out_second_oe(int2_oe),
    .o_bus_live(live));

  host_bus_model host_u (
    .i_clk(i_clk), .i_dev_oe(doe), .i_dev_data(odata), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_data(hdata));

  initial begin
    i_clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  task automatic chk(input logic [7:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk

  task automatic wait_live(output int n);
    n = 0;
    while (live !== 1'h1 && n < RC + 20) begin
      @(posedge i_clk);
      n++;
    end
  endtask : wait_live

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic s;
    host_u.rd(a, q, s);
    chk({7'h00, s}, 8'h01, "read not driven");
    chk(q, exp, "read data");
  endtask : rd_chk

  task automatic t_power();
    int n;
    wait_live(n);
    chk({7'h00, n >= RC && n <= RC + 5}, 8'h01, "recovery time");
    $display("test power done");
  endtask : t_power

  task automatic t_rw();
    logic [5:0] at [5] = '{6'h00, 6'h0d, 6'h0e, 6'h2a, 6'h3f};
    logic [7:0] dt [5] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'h96};
    for (int i = 0; i < 5; i++) host_u.wr(at[i], dt[i]);
    for (int i = 0; i < 5; i++) rd_chk(at[i], dt[i]);
    @(posedge i_clk);
    cwr <= 1'h1;
    caddr <= 6'h0d;
    cdata <= 8'h77;
    @(posedge i_clk);
    caddr <= 6'h0e;
    cdata <= 8'h11;
    @(posedge i_clk);
    cwr <= 1'h0;
    rd_chk(6'h0d, 8'h77);
    rd_chk(6'h0e, 8'h0f);
    $display("test read write done");
  endtask : t_rw

  task automatic t_edges();
    host_u.step(1'h0, 1'h1, 1'h1, 6'h20, 8'h11, 1'h1, 3);
    host_u.step(1'h0, 1'h1, 1'h0, 6'h20, 8'hc3, 1'h1, 4);
    host_u.step(1'h1, 1'h1, 1'h0, 6'h20, 8'hc3, 1'h1, 3);
    host_u.step(1'h1, 1'h1, 1'h0, 6'h20, 8'h3c, 1'h1, 3);
    host_u.step(1'h1, 1'h1, 1'h1, 6'h20, 8'h3c, 1'h1, 3);
    host_u.step(1'h1, 1'h1, 1'h1, 6'h20, 8'h3c, 1'h0, 3);
    rd_chk(6'h20, 8'hc3);
    $display("test strobe edges done");
  endtask : t_edges

  task automatic t_odis();
    host_u.step(1'h0, 1'h0, 1'h1, 6'h0e, 8'h00, 1'h0, 5);
    chk({7'h00, doe}, 8'h01, "read drive");
    host_u.step(1'h0, 1'h0, 1'h0, 6'h0e, 8'h5c, 1'h1, 5);
    chk({7'h00, doe}, 8'h00, "output disable");
    host_u.step(1'h1, 1'h1, 1'h1, 6'h0e, 8'h5c, 1'h1, 3);
    host_u.step(1'h1, 1'h1, 1'h1, 6'h0e, 8'h5c, 1'h0, 3);
    rd_chk(6'h0e, 8'h5c);
    $display("test output disable done");
  endtask : t_odis

  task automatic t_supply();
    logic [7:0] q;
    logic s;
    int n;
    host_u.wr(6'h30, 8'h81);
    host_u.wr(6'h31, 8'h22);
    // Supply drops while a write to 31 is still open: it must be lost
    host_u.step(1'h0, 1'h1, 1'h0, 6'h31, 8'h44, 1'h1, 4);
    sup <= 1'h0;
    tick(5);
    chk({7'h00, live}, 8'h00, "live while down");
    host_u.step(1'h1, 1'h1, 1'h1, 6'h31, 8'h44, 1'h1, 3);
    host_u.wr(6'h30, 8'h7e);
    host_u.rd(6'h30, q, s);
    chk({7'h00, s}, 8'h00, "driven while down");
    @(posedge i_clk);
    sup <= 1'h1;
    wait_live(n);
    chk({7'h00, n >= RC && n <= RC + 5}, 8'h01, "recovery again");
    rd_chk(6'h30, 8'h81);
    rd_chk(6'h31, 8'h22);
    $display("test supply done");
  endtask : t_supply

  task automatic t_irq();
    int n;
    @(posedge i_clk);
    irq1 <= 1'h1;
    irq2 <= 1'h1;
    tick(2);
    chk({int1, int1_oe, int2, int2_oe}, 8'h05, "irq asserted");
    irq1 <= 1'h0;
    irq2 <= 1'h0;
    tick(2);
    chk({int1, int1_oe, int2, int2_oe}, 8'h00, "irq released");
    act_hi <= 1'h1;
    irq2 <= 1'h1;
    tick(2);
    chk({7'h00, int2_oe}, 8'h00, "second high");
    sup <= 1'h0;
    irq1 <= 1'h1;
    tick(5);
    chk({int1_oe, int2_oe}, 8'h03, "irq on backup");
    sup <= 1'h1;
    irq1 <= 1'h0;
    irq2 <= 1'h0;
    act_hi <= 1'h0;
    wait_live(n);
    $display("test interrupts done");
  endtask : t_irq

  task automatic t_reset();
    int n;
    @(posedge i_clk);
    i_rst <= 1'h1;
    irq1 <= 1'h1;
    tick(3);
    chk({doe, int1_oe, int2_oe, live}, 8'h00, "outputs in reset");
    i_rst <= 1'h0;
    irq1 <= 1'h0;
    wait_live(n);
    chk({7'h00, n >= RC && n <= RC + 5}, 8'h01, "recovery reset");
    // Register contents survive a logic reset
    rd_chk(6'h30, 8'h81);
    $display("test reset done");
  endtask : t_reset

  initial begin
    i_rst = 1'h1;
    sup = 1'h1;
    cwr = 1'h0;
    caddr = 6'h00;
    cdata = 8'h00;
    irq1 = 1'h0;
    irq2 = 1'h0;
    act_hi = 1'h0;
    tick(3);
    i_rst <= 1'h0;
    t_power();
    t_rw();
    t_edges();
    t_odis();
    t_supply();
    t_irq();
    t_reset();
    print_verdict();
  end
endmodule : async_bytewide_register_port_tb
`default_nettype wire
